// *** common/buck_regs_pkg.sv ***
// Package with register map, field layout, timing and carrier types for the buck control bank
package buck_regs_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_BUCK1_SLEEP_VOLTAGE = 8'h34;
    localparam logic [7:0] IDX_BUCK1_CONTROL = 8'h35;
    localparam logic [7:0] IDX_BUCK1_SECONDARY_CONTROL = 8'h36;
    localparam logic [7:0] IDX_BUCK2_RUN_VOLTAGE = 8'h38;
    localparam logic [7:0] IDX_BUCK2_STANDBY_VOLTAGE = 8'h39;
    localparam logic [7:0] IDX_BUCK2_SLEEP_VOLTAGE = 8'h3A;

    localparam int unsigned APB_ADDR_W = 12;
    localparam int unsigned APB_DATA_W = 32;
    localparam int unsigned CODE_W = 6;

    // Field positions
    localparam int unsigned CODE_MSB = 5;
    localparam int unsigned CTRL_RUN_EN_BIT = 0;
    localparam int unsigned CTRL_STBY_EN_BIT = 1;
    localparam int unsigned CTRL_SLEEP_EN_BIT = 2;
    localparam int unsigned CTRL_LPWR_BIT = 3;
    localparam int unsigned CTRL_SLEW_BIT = 4;
    localparam int unsigned CTRL_FPWM_RAMP_BIT = 5;
    localparam int unsigned CTRL_FPWM_BIT = 6;
    localparam int unsigned CTRL_DIS_N_BIT = 7;
    localparam int unsigned SEC_ILIM_LSB = 0;
    localparam int unsigned SEC_ILIM_MSB = 1;
    localparam int unsigned SEC_TMODE_BIT = 4;

    // Reset values before the fuse load
    localparam logic [5:0] CODE_RESET = 6'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] ILIM_RESET = 2'h0;
    localparam logic TMODE_RESET = 1'b0;

    // Power mode codes on the mode pins
    localparam logic [1:0] PM_RUN = 2'h0;
    localparam logic [1:0] PM_STANDBY = 2'h1;
    localparam logic [1:0] PM_SLEEP = 2'h2;

    // Scaling slew: one code step per period
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned SLEW_FAST_US = 2;
    localparam int unsigned SLEW_SLOW_US = 4;
    localparam int unsigned SLEW_FAST_CYCLES = SLEW_FAST_US * CLK_MHZ;
    localparam int unsigned SLEW_SLOW_CYCLES = SLEW_SLOW_US * CLK_MHZ;

    // Edges after reset release before the synchronised fuse word is trusted
    localparam logic [1:0] FUSE_LOAD_WAIT = 2'h2;

    typedef struct packed {
        logic scaling_select;
        logic [5:0] buck1_run_code;
        logic [5:0] buck2_run_code;
        logic run_enable;
        logic slew_slow;
        logic discharge_disable_n;
        logic [1:0] current_limit;
    } fuse_t;

    // Same bit order as the control register, bit 7 first
    typedef struct packed {
        logic discharge_disable_n;
        logic forced_pwm;
        logic forced_pwm_on_ramp_down;
        logic scaling_slew_select;
        logic low_power_entry;
        logic sleep_enable;
        logic standby_enable;
        logic run_enable;
    } buck1_ctrl_t;

    typedef struct packed {
        logic enable;
        logic low_power;
        logic forced_pwm;
        logic discharge;
        logic [5:0] code;
    } buck_out_t;

    typedef enum logic [2:0] {
        RAMP_IDLE = 3'b001,
        RAMP_UP = 3'b010,
        RAMP_DOWN = 3'b100
    } ramp_state_t;

endpackage

// *** core/buck_regulator_control_regs.sv ***
// Register bank and mode logic for the two buck regulators, APB slave
//
// Summary of operation
// - Buck one sleep code, fuse run code at power-on
// - Control bit 0 enables buck one in run
// - Bit 1 standby enable, starts as run enable
// - Bit 2 sleep enable, resets 0, set on the clock from the synchronised pin
// - Bit 3 low power in standby and sleep
// - Bit 4 picks slew, ignored when fuse selects
// - Bit 5 forces continuous conduction while ramping down
// - Bit 6 forces PWM regardless of load
// - Bit 7 low connects discharge when disabled
// - Secondary bits 1:0 current limit, loaded from fuses
// - Secondary bit 4 picks on/off time control
// - Buck two run code loaded from fuses
// - Buck two standby code starts as run code
// - Buck two sleep code starts as run code
// - Fuse-loaded fields stay readable and writable
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module buck_regulator_control_regs
    import buck_regs_pkg::*;
#(
    parameter int unsigned STEP_FAST_CYCLES = SLEW_FAST_CYCLES,
    parameter int unsigned STEP_SLOW_CYCLES = SLEW_SLOW_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [APB_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [APB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fuse_t fuse_values,
    input wire logic [1:0] power_mode,
    input wire logic buck1_sleep_enable_set,
    input wire logic [5:0] buck1_run_voltage_code,
    input wire logic [5:0] buck1_standby_voltage_code,
    output buck_out_t buck1_out,
    output logic [1:0] buck1_current_limit,
    output logic buck1_timing_control_select,
    output logic buck1_ramp_active,
    output logic [5:0] buck2_code,
    output logic fuse_loaded
);

    initial begin
        if (STEP_FAST_CYCLES < 2 || STEP_SLOW_CYCLES < 2 || STEP_FAST_CYCLES > 4095 ||
            STEP_SLOW_CYCLES > 4095) begin
            $error("step period counts must lie in 2..4095");
        end
    end

    localparam logic [11:0] FAST_RELOAD = 12'(STEP_FAST_CYCLES - 1);
    localparam logic [11:0] SLOW_RELOAD = 12'(STEP_SLOW_CYCLES - 1);

    // Word index of a bus address; upper address bits must be zero to hit
    function automatic logic hit(input logic [APB_ADDR_W-1:0] addr, input logic [7:0] idx);
        hit = (addr[APB_ADDR_W-1:2] == {idx, 2'h0} >> 2) && (addr[1:0] == 2'h0);
    endfunction

    // Pin synchronisers
    fuse_t fuse_meta_r;
    fuse_t fuse_sync_r;
    logic [1:0] mode_meta_r;
    logic [1:0] mode_sync_r;
    logic set_meta_r;
    logic set_sync_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_meta_r <= '0;
            fuse_sync_r <= '0;
            mode_meta_r <= PM_RUN;
            mode_sync_r <= PM_RUN;
            set_meta_r <= 1'b0;
            set_sync_r <= 1'b0;
        end else begin
            fuse_meta_r <= fuse_values;
            fuse_sync_r <= fuse_meta_r;
            mode_meta_r <= power_mode;
            mode_sync_r <= mode_meta_r;
            set_meta_r <= buck1_sleep_enable_set;
            set_sync_r <= set_meta_r;
        end
    end

    // The two mode bits may settle on different edges; a new mode is taken only
    // once two successive synchronised samples agree, so no false mode shows
    logic [1:0] mode_prev_r;
    logic [1:0] mode_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_prev_r <= PM_RUN;
            mode_r <= PM_RUN;
        end else begin
            mode_prev_r <= mode_sync_r;
            if (mode_sync_r == mode_prev_r) begin
                mode_r <= mode_sync_r;
            end
        end
    end

    // One-shot fuse load once the synchronised fuse word has settled
    logic [1:0] load_cnt_r;
    logic fuse_loaded_r;
    logic fuse_load;

    assign fuse_load = !fuse_loaded_r && (load_cnt_r == FUSE_LOAD_WAIT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_cnt_r <= 2'h0;
            fuse_loaded_r <= 1'b0;
        end else if (!fuse_loaded_r) begin
            load_cnt_r <= 2'(load_cnt_r + 2'h1);
            fuse_loaded_r <= fuse_load;
        end
    end

    // APB transfer decode: zero wait states, pready raised in the access cycle
    logic setup_phase;
    logic wr_en;
    logic any_hit;
    logic [APB_DATA_W-1:0] rd_value;

    assign setup_phase = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && pstrb[0] && !pslverr;

    // Storage
    logic [5:0] b1_sleep_code_r;
    buck1_ctrl_t b1_ctrl_r;
    logic [1:0] b1_ilim_r;
    logic b1_tmode_r;
    logic [5:0] b2_run_code_r;
    logic [5:0] b2_stby_code_r;
    logic [5:0] b2_sleep_code_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b1_sleep_code_r <= CODE_RESET;
        end else if (fuse_load) begin
            b1_sleep_code_r <= fuse_sync_r.buck1_run_code;
        end else if (wr_en && hit(paddr, IDX_BUCK1_SLEEP_VOLTAGE)) begin
            b1_sleep_code_r <= pwdata[CODE_MSB:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b1_ctrl_r <= CTRL_RESET;
        end else begin
            if (fuse_load) begin
                b1_ctrl_r.run_enable <= fuse_sync_r.run_enable;
                b1_ctrl_r.standby_enable <= fuse_sync_r.run_enable;
                b1_ctrl_r.scaling_slew_select <= fuse_sync_r.slew_slow;
                b1_ctrl_r.discharge_disable_n <= fuse_sync_r.discharge_disable_n;
            end else if (wr_en && hit(paddr, IDX_BUCK1_CONTROL)) begin
                b1_ctrl_r <= buck1_ctrl_t'(pwdata[7:0]);
            end
            // Hardware set wins over a software clear in the same cycle
            if (set_sync_r) begin
                b1_ctrl_r.sleep_enable <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b1_ilim_r <= ILIM_RESET;
            b1_tmode_r <= TMODE_RESET;
        end else if (fuse_load) begin
            b1_ilim_r <= fuse_sync_r.current_limit;
        end else if (wr_en && hit(paddr, IDX_BUCK1_SECONDARY_CONTROL)) begin
            b1_ilim_r <= pwdata[SEC_ILIM_MSB:SEC_ILIM_LSB];
            b1_tmode_r <= pwdata[SEC_TMODE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b2_run_code_r <= CODE_RESET;
            b2_stby_code_r <= CODE_RESET;
            b2_sleep_code_r <= CODE_RESET;
        end else if (fuse_load) begin
            b2_run_code_r <= fuse_sync_r.buck2_run_code;
            b2_stby_code_r <= fuse_sync_r.buck2_run_code;
            b2_sleep_code_r <= fuse_sync_r.buck2_run_code;
        end else if (wr_en) begin
            if (hit(paddr, IDX_BUCK2_RUN_VOLTAGE)) begin
                b2_run_code_r <= pwdata[CODE_MSB:0];
            end
            if (hit(paddr, IDX_BUCK2_STANDBY_VOLTAGE)) begin
                b2_stby_code_r <= pwdata[CODE_MSB:0];
            end
            if (hit(paddr, IDX_BUCK2_SLEEP_VOLTAGE)) begin
                b2_sleep_code_r <= pwdata[CODE_MSB:0];
            end
        end
    end

    // Read value; bits above the fields stay zero
    always_comb begin
        rd_value = '0;
        any_hit = 1'b1;
        if (hit(paddr, IDX_BUCK1_SLEEP_VOLTAGE)) begin
            rd_value[CODE_MSB:0] = b1_sleep_code_r;
        end else if (hit(paddr, IDX_BUCK1_CONTROL)) begin
            rd_value[7:0] = b1_ctrl_r;
        end else if (hit(paddr, IDX_BUCK1_SECONDARY_CONTROL)) begin
            rd_value[SEC_ILIM_MSB:SEC_ILIM_LSB] = b1_ilim_r;
            rd_value[SEC_TMODE_BIT] = b1_tmode_r;
        end else if (hit(paddr, IDX_BUCK2_RUN_VOLTAGE)) begin
            rd_value[CODE_MSB:0] = b2_run_code_r;
        end else if (hit(paddr, IDX_BUCK2_STANDBY_VOLTAGE)) begin
            rd_value[CODE_MSB:0] = b2_stby_code_r;
        end else if (hit(paddr, IDX_BUCK2_SLEEP_VOLTAGE)) begin
            rd_value[CODE_MSB:0] = b2_sleep_code_r;
        end else begin
            any_hit = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (setup_phase) begin
            pready <= 1'b1;
            pslverr <= !any_hit;
            prdata <= pwrite ? '0 : rd_value;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
    end

    // Mode-dependent selection of target code and enable
    logic [5:0] b1_target;
    logic b1_mode_enable;
    logic low_power_mode;

    always_comb begin
        case (mode_r)
            PM_STANDBY: begin
                b1_target = buck1_standby_voltage_code;
                b1_mode_enable = b1_ctrl_r.standby_enable;
                low_power_mode = 1'b1;
            end
            PM_SLEEP: begin
                b1_target = b1_sleep_code_r;
                b1_mode_enable = b1_ctrl_r.sleep_enable;
                low_power_mode = 1'b1;
            end
            default: begin
                b1_target = buck1_run_voltage_code;
                b1_mode_enable = b1_ctrl_r.run_enable;
                low_power_mode = 1'b0;
            end
        endcase
    end

    // Voltage scaling ramp: one code step per slew period toward the target
    ramp_state_t ramp_r;
    ramp_state_t ramp_nxt;
    logic [11:0] step_cnt_r;
    logic [5:0] b1_code_r;
    logic step_due;
    logic slow_slew;

    // The fuse scaling option overrides the register bit with the fast rate
    assign slow_slew = !fuse_sync_r.scaling_select && b1_ctrl_r.scaling_slew_select;
    assign step_due = (step_cnt_r == 12'h000);

    always_comb begin
        ramp_nxt = RAMP_IDLE;
        if (b1_target > b1_code_r) begin
            ramp_nxt = RAMP_UP;
        end else if (b1_target < b1_code_r) begin
            ramp_nxt = RAMP_DOWN;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_r <= RAMP_IDLE;
        end else begin
            ramp_r <= ramp_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cnt_r <= 12'h000;
        end else if (ramp_r == RAMP_IDLE || step_due) begin
            step_cnt_r <= slow_slew ? SLOW_RELOAD : FAST_RELOAD;
        end else begin
            step_cnt_r <= 12'(step_cnt_r - 12'h001);
        end
    end

    // Code holds zero until the fuse load, then ramps; while disabled it jumps to target
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b1_code_r <= CODE_RESET;
        end else if (!fuse_loaded_r) begin
            b1_code_r <= CODE_RESET;
        end else if (!buck1_out.enable && !b1_mode_enable) begin
            b1_code_r <= b1_target;
        end else if (step_due) begin
            case (ramp_r)
                RAMP_UP: begin
                    if (b1_target > b1_code_r) begin
                        b1_code_r <= 6'(b1_code_r + 6'h01);
                    end
                end
                RAMP_DOWN: begin
                    if (b1_target < b1_code_r) begin
                        b1_code_r <= 6'(b1_code_r - 6'h01);
                    end
                end
                default: begin
                    b1_code_r <= b1_code_r;
                end
            endcase
        end
    end

    // Output stage, every output registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buck1_out <= '0;
            buck1_ramp_active <= 1'b0;
        end else begin
            buck1_out.code <= b1_code_r;
            buck1_out.enable <= fuse_loaded_r && b1_mode_enable;
            buck1_out.low_power <= b1_ctrl_r.low_power_entry && low_power_mode;
            buck1_out.forced_pwm <= b1_ctrl_r.forced_pwm ||
                (b1_ctrl_r.forced_pwm_on_ramp_down && ramp_r == RAMP_DOWN);
            buck1_out.discharge <= !b1_ctrl_r.discharge_disable_n &&
                !(fuse_loaded_r && b1_mode_enable);
            buck1_ramp_active <= (ramp_r != RAMP_IDLE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buck1_current_limit <= ILIM_RESET;
            buck1_timing_control_select <= TMODE_RESET;
            buck2_code <= CODE_RESET;
            fuse_loaded <= 1'b0;
        end else begin
            buck1_current_limit <= b1_ilim_r;
            buck1_timing_control_select <= b1_tmode_r;
            case (mode_r)
                PM_STANDBY: buck2_code <= b2_stby_code_r;
                PM_SLEEP: buck2_code <= b2_sleep_code_r;
                default: buck2_code <= b2_run_code_r;
            endcase
            fuse_loaded <= fuse_loaded_r;
        end
    end

endmodule

`default_nettype wire

// *** verification/buck_regulator_control_regs_properties.sv ***
// Checker for bus handshake and output relations of the buck register bank
`timescale 1ns/1ps
`default_nettype none
module buck_regulator_control_regs_properties
    import buck_regs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [APB_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire buck_out_t buck1_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        pready;
    endsequence
    property p_answer;
        s_setup |=> s_access;
    endproperty
    property p_single;
        pready |=> !pready;
    endproperty
    property p_cause;
        pready |-> $past(psel && !penable);
    endproperty
    property p_idle_zero;
        !pready |-> prdata == '0 && !pslverr;
    endproperty
    property p_err_zero;
        pslverr |-> pready && prdata == '0;
    endproperty
    property p_upper_zero;
        pready |-> prdata[31:8] == '0;
    endproperty
    property p_discharge;
        buck1_out.discharge |-> !buck1_out.enable;
    endproperty
    // Only while enabled on both edges; a disabled buck may jump to its target
    property p_step;
        buck1_out.enable && $past(buck1_out.enable) && $changed(buck1_out.code) |->
            buck1_out.code == $past(buck1_out.code) + 6'h01 ||
            buck1_out.code + 6'h01 == $past(buck1_out.code);
    endproperty
    a_answer: assert property (p_answer) else $error("no answer after setup");
    a_single: assert property (p_single) else $error("ready longer than one cycle");
    a_cause: assert property (p_cause) else $error("ready without setup");
    a_idle_zero: assert property (p_idle_zero) else $error("read data outside access");
    a_err_zero: assert property (p_err_zero) else $error("error with data or no ready");
    a_upper_zero: assert property (p_upper_zero) else $error("unused bits not zero");
    a_discharge: assert property (p_discharge) else $error("discharge while enabled");
    a_step: assert property (p_step) else $error("code moved more than one step");
endmodule
bind buck_regulator_control_regs buck_regulator_control_regs_properties u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .buck1_out(buck1_out));
`default_nettype wire

// *** verification/tb_buck_regulator_control_regs.sv ***
// Self-checking bench for the buck register bank over APB
`timescale 1ns/1ps
`default_nettype none
module tb_buck_regulator_control_regs
    import buck_regs_pkg::*;
;
    localparam int FAST = 4;
    localparam int SLOW = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_set;
    logic [APB_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    fuse_t fuse_values;
    logic [1:0] power_mode, ilim;
    logic [5:0] run_code, stby_code, buck2_code;
    buck_out_t buck1_out;
    logic tsel, ramp, fuse_loaded, e;
    int err_count, check_count, n;
    logic [7:0] idxs [6] = '{8'h34, 8'h35, 8'h36, 8'h38, 8'h39, 8'h3A};
    logic [31:0] msk [6] = '{32'h3F, 32'hFF, 32'h13, 32'h3F, 32'h3F, 32'h3F};
    logic [1:0] pms [3] = '{PM_RUN, PM_STANDBY, PM_SLEEP};
    logic [2:0] e3 [3] = '{3'b100, 3'b011, 3'b110};
    logic [5:0] b2 [3] = '{6'h11, 6'h22, 6'h33};

    buck_regulator_control_regs #(.STEP_FAST_CYCLES(FAST), .STEP_SLOW_CYCLES(SLOW)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fuse_values(fuse_values), .power_mode(power_mode),
        .buck1_sleep_enable_set(sleep_set), .buck1_run_voltage_code(run_code),
        .buck1_standby_voltage_code(stby_code), .buck1_out(buck1_out),
        .buck1_current_limit(ilim), .buck1_timing_control_select(tsel),
        .buck1_ramp_active(ramp), .buck2_code(buck2_code), .fuse_loaded(fuse_loaded));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task complete_run;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            err_count++;
            complete_run();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] idx, input logic [31:0] d);
        apb({2'h0, idx, 2'h0}, 1'b1, d);
    endtask

    task rdc(input logic [7:0] idx, input logic [31:0] exp);
        apb({2'h0, idx, 2'h0}, 1'b0, 32'h0);
        chk(rd, exp);
        chk({31'h0, e}, 32'h0);
    endtask

    // Pins pass two synchronisers, the mode filter and one output register
    task settle;
        repeat (6) @(posedge pclk);
    endtask

    task wait_idle;
        int i;
        i = 0;
        settle();
        while (ramp !== 1'b0 && i < 2000) begin
            @(posedge pclk);
            i++;
        end
        if (ramp !== 1'b0) begin
            err_count++;
            complete_run();
        end
    endtask

    // Cycles between two successive code steps
    task gap(input int exp);
        int i;
        logic [5:0] c;
        for (int k = 0; k < 2; k++) begin
            c = buck1_out.code;
            i = 0;
            while (buck1_out.code === c && i < 100) begin
                @(posedge pclk);
                i++;
            end
        end
        chk(i, exp);
    endtask

    initial begin
        {psel, penable, pwrite, sleep_set, presetn} = 5'h0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        fuse_values = '{scaling_select: 1'b0, buck1_run_code: 6'h15, buck2_run_code: 6'h2A,
            run_enable: 1'b1, slew_slow: 1'b1, discharge_disable_n: 1'b0, current_limit: 2'h2};
        power_mode = PM_RUN;
        run_code = 6'h15;
        stby_code = 6'h10;
        err_count = 0;
        check_count = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        n = 0;
        while (fuse_loaded !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, fuse_loaded}, 32'h1);
        rdc(IDX_BUCK1_SLEEP_VOLTAGE, 32'h15);
        rdc(IDX_BUCK1_CONTROL, 32'h13);
        rdc(IDX_BUCK1_SECONDARY_CONTROL, 32'h02);
        rdc(IDX_BUCK2_RUN_VOLTAGE, 32'h2A);
        rdc(IDX_BUCK2_STANDBY_VOLTAGE, 32'h2A);
        rdc(IDX_BUCK2_SLEEP_VOLTAGE, 32'h2A);
        chk({tsel, ilim}, 32'h2);
        apb(12'h0DC, 1'b0, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(12'h0D1, 1'b1, 32'h3F);
        chk({31'h0, e}, 32'h1);
        rdc(IDX_BUCK1_SLEEP_VOLTAGE, 32'h15);
        // Ramp down at the slow rate, then fast, with forced conduction on the way down
        wait_idle();
        chk(buck1_out.code, 32'h15);
        wr(IDX_BUCK1_CONTROL, 32'h31);
        run_code <= 6'h05;
        gap(SLOW);
        chk({ramp, buck1_out.forced_pwm}, 32'h3);
        wr(IDX_BUCK1_CONTROL, 32'h21);
        gap(FAST);
        wait_idle();
        chk({buck1_out.forced_pwm, buck1_out.code}, 32'h05);
        for (int k = 0; k < 6; k++) begin
            wr(idxs[k], 32'hFFFF_FFFF);
            rdc(idxs[k], msk[k]);
            wr(idxs[k], 32'h0);
            rdc(idxs[k], 32'h0);
        end
        wr(IDX_BUCK2_RUN_VOLTAGE, 32'h11);
        wr(IDX_BUCK2_STANDBY_VOLTAGE, 32'h22);
        wr(IDX_BUCK2_SLEEP_VOLTAGE, 32'h33);
        wr(IDX_BUCK1_CONTROL, 32'h0D);
        for (int k = 0; k < 3; k++) begin
            power_mode <= pms[k];
            settle();
            chk({buck1_out.enable, buck1_out.low_power, buck1_out.discharge}, e3[k]);
            chk(buck2_code, b2[k]);
        end
        power_mode <= PM_RUN;
        wr(IDX_BUCK1_CONTROL, 32'h40);
        settle();
        chk({buck1_out.enable, buck1_out.forced_pwm, buck1_out.discharge}, 32'h3);
        wr(IDX_BUCK1_CONTROL, 32'hC1);
        settle();
        chk({buck1_out.enable, buck1_out.discharge}, 32'h2);
        wr(IDX_BUCK1_CONTROL, 32'hC0);
        settle();
        chk({buck1_out.enable, buck1_out.discharge}, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr(IDX_BUCK1_SECONDARY_CONTROL, {27'h0, k[0], 2'h0, k[1:0]});
            settle();
            chk({tsel, ilim}, {k[0], k[1:0]});
        end
        wr(IDX_BUCK1_CONTROL, 32'h0);
        sleep_set <= 1'b1;
        settle();
        wr(IDX_BUCK1_CONTROL, 32'h0);
        rdc(IDX_BUCK1_CONTROL, 32'h04);
        sleep_set <= 1'b0;
        settle();
        wr(IDX_BUCK1_CONTROL, 32'h0);
        rdc(IDX_BUCK1_CONTROL, 32'h0);
        // Fuse scaling option forces the fast rate over a slow register setting
        fuse_values.scaling_select <= 1'b1;
        wr(IDX_BUCK1_CONTROL, 32'h11);
        run_code <= 6'h0A;
        gap(FAST);
        complete_run();
    end
endmodule
`default_nettype wire
